// ### verilog/timer_capture_compare_channels.sv
// eight-channel timer capture/compare block with avalon-mm registers
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
module timer_capture_compare_channels #(
  parameter int CHANNELS = timer_cc_pkg::CHANNELS,
  parameter int COUNT_WIDTH = timer_cc_pkg::COUNT_WIDTH
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic o_irq,
  input wire logic [7:0] i_capture_pin,
  output logic [7:0] o_pin_out,
  output logic [7:0] o_pin_oe
);

  // ****************************************
  // bus handshake
  // ****************************************
  timer_cc_pkg::bus_state_type state_reg;
  timer_cc_pkg::bus_state_type state_next;
  logic waitrequest_reg;
  logic [31:0] readdata_reg;
  logic [31:0] rd_word;
  logic [5:0] reg_index;
  logic bus_req;
  logic take_req;
  logic write_now;

  assign reg_index = i_address[7:2];
  assign bus_req = i_read | i_write;
  assign take_req = (state_reg == timer_cc_pkg::BUS_IDLE) & bus_req;
  assign write_now = (state_reg == timer_cc_pkg::BUS_ANSWER) & i_write;

  always_comb begin
    case (state_reg)
      timer_cc_pkg::BUS_IDLE: begin
        state_next = bus_req ? timer_cc_pkg::BUS_ANSWER :
                               timer_cc_pkg::BUS_IDLE;
      end
      timer_cc_pkg::BUS_ANSWER: begin
        state_next = timer_cc_pkg::BUS_IDLE;
      end
      default: begin
        state_next = timer_cc_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= timer_cc_pkg::BUS_IDLE;
      waitrequest_reg <= 1'b1;
      readdata_reg <= timer_cc_pkg::WORD_ZERO;
    end else begin
      state_reg <= state_next;
      waitrequest_reg <= ~take_req;
      readdata_reg <= (take_req & i_read) ? rd_word : readdata_reg;
    end
  end

  // ****************************************
  // write decode
  // ****************************************
  logic wr_dir;
  logic wr_force;
  logic wr_mask;
  logic wr_data7;
  logic wr_sys;
  logic wr_out;
  logic wr_edge_hi;
  logic wr_edge_lo;
  logic wr_irq_en;
  logic wr_port;
  logic wr_clear;
  logic wr_value_hit;

  assign wr_dir = write_now & (reg_index == timer_cc_pkg::IDX_DIRECTION);
  assign wr_force = write_now & (reg_index == timer_cc_pkg::IDX_FORCE);
  assign wr_mask = write_now & (reg_index == timer_cc_pkg::IDX_OC7_MASK);
  assign wr_data7 = write_now & (reg_index == timer_cc_pkg::IDX_OC7_DATA);
  assign wr_sys = write_now & (reg_index == timer_cc_pkg::IDX_SYS_CTRL);
  assign wr_out = write_now & (reg_index == timer_cc_pkg::IDX_OUT_CTRL);
  assign wr_edge_hi = write_now &
                      (reg_index == timer_cc_pkg::IDX_EDGE_HIGH);
  assign wr_edge_lo = write_now &
                      (reg_index == timer_cc_pkg::IDX_EDGE_CTRL);
  assign wr_irq_en = write_now &
                     (reg_index == timer_cc_pkg::IDX_IRQ_ENABLE);
  assign wr_port = write_now & (reg_index == timer_cc_pkg::IDX_PORT_LATCH);
  assign wr_clear = write_now & (reg_index == timer_cc_pkg::IDX_CLEAR);
  assign wr_value_hit = write_now &
    (reg_index[5:3] == timer_cc_pkg::IDX_CH_VALUE_BASE[5:3]);

  // ****************************************
  // software registers
  // ****************************************
  logic [7:0] dir_reg;
  logic [7:0] mask7_reg;
  logic [7:0] data7_reg;
  logic [7:0] irq_en_reg;
  logic [15:0] out_ctrl_reg;
  logic [15:0] edge_ctrl_reg;
  timer_cc_pkg::sys_ctrl_type sys_reg;
  timer_cc_pkg::port_latch_type port_reg;
  logic [15:0] edge_ctrl_next;

  assign edge_ctrl_next = {
    wr_edge_hi ? i_writedata[7:0] : edge_ctrl_reg[15:8],
    wr_edge_lo ? i_writedata[7:0] : edge_ctrl_reg[7:0]};

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dir_reg <= timer_cc_pkg::BYTE_RESET;
      mask7_reg <= timer_cc_pkg::BYTE_RESET;
      data7_reg <= timer_cc_pkg::BYTE_RESET;
      irq_en_reg <= timer_cc_pkg::BYTE_RESET;
      out_ctrl_reg <= timer_cc_pkg::HALF_RESET;
      edge_ctrl_reg <= timer_cc_pkg::HALF_RESET;
      sys_reg <= timer_cc_pkg::SYS_CTRL_RESET;
      port_reg <= timer_cc_pkg::PORT_LATCH_RESET;
    end else begin
      dir_reg <= wr_dir ? i_writedata[7:0] : dir_reg;
      mask7_reg <= wr_mask ? i_writedata[7:0] : mask7_reg;
      data7_reg <= wr_data7 ? i_writedata[7:0] : data7_reg;
      irq_en_reg <= wr_irq_en ? i_writedata[7:0] : irq_en_reg;
      out_ctrl_reg <= wr_out ? i_writedata[15:0] : out_ctrl_reg;
      edge_ctrl_reg <= edge_ctrl_next;
      sys_reg <= wr_sys ? timer_cc_pkg::sys_ctrl_type'(i_writedata[4:0]) :
                          sys_reg;
      // pin never written here, only the latch
      port_reg <= wr_port ? i_writedata[15:0] : port_reg;
    end
  end

  // ****************************************
  // prescaler and counter
  // ****************************************
  logic [6:0] pres_cnt_reg;
  logic [6:0] pres_cnt_next;
  logic [6:0] pres_mask;
  logic [COUNT_WIDTH-1:0] counter_reg;
  logic [COUNT_WIDTH-1:0] counter_next;
  logic fresh_reg;
  logic tick;
  logic wrap;
  logic [CHANNELS-1:0][COUNT_WIDTH-1:0] values;

  assign pres_mask = 7'((8'h01 << sys_reg.prescale) - 8'h01);
  assign pres_cnt_next = sys_reg.timer_enable ? 7'(pres_cnt_reg + 7'h01) :
                                                pres_cnt_reg;
  assign tick = sys_reg.timer_enable &
                ((pres_cnt_reg & pres_mask) == pres_mask);
  // match on channel seven returns counter to zero
  assign wrap = sys_reg.timer_enable & sys_reg.counter_reset_enable &
                (values[7] != timer_cc_pkg::COUNT_RESET) &
                (counter_reg == values[7]);
  assign counter_next = wrap ? timer_cc_pkg::COUNT_RESET :
                        tick ? COUNT_WIDTH'(counter_reg + 1'b1) :
                               counter_reg;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pres_cnt_reg <= timer_cc_pkg::PRESCALE_RESET;
      counter_reg <= timer_cc_pkg::COUNT_RESET;
      fresh_reg <= 1'b0;
    end else begin
      pres_cnt_reg <= pres_cnt_next;
      counter_reg <= counter_next;
      fresh_reg <= wrap | tick;
    end
  end

  // ****************************************
  // capture and compare per channel
  // ****************************************
  logic [7:0] pin_prev_reg;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] cap_evt;
  logic [7:0] cmp_hit;
  logic [7:0] oc_fire;
  logic [7:0] force_pulse;
  logic [7:0] act;
  logic [7:0] owned;
  logic [7:0] oc_state_reg;
  logic [7:0] oc_state_next;
  logic [7:0] pin_out_next;
  logic [7:0] pin_oe_next;
  logic [7:0] value_we;
  logic ch7_fire;

  assign rise = i_capture_pin & ~pin_prev_reg;
  assign fall = ~i_capture_pin & pin_prev_reg;
  assign force_pulse = wr_force ? (i_writedata[7:0] & dir_reg) :
                                  timer_cc_pkg::BYTE_RESET;
  assign act = oc_fire | force_pulse;
  assign ch7_fire = act[7];

  genvar n;
  generate
    for (n = 0; n < CHANNELS; n++) begin : g_chan
      timer_cc_pkg::capture_edge_type edge_sel;
      timer_cc_pkg::out_action_type action;
      logic acted;
      assign edge_sel = timer_cc_pkg::capture_edge_type'(
                          edge_ctrl_reg[2*n+1:2*n]);
      assign action = timer_cc_pkg::out_action_type'(
                        out_ctrl_reg[2*n+1:2*n]);
      assign cap_evt[n] = ~dir_reg[n] &
        ((edge_sel[0] & rise[n]) | (edge_sel[1] & fall[n]));
      assign cmp_hit[n] = fresh_reg & (counter_reg == values[n]);
      assign oc_fire[n] = dir_reg[n] & cmp_hit[n];
      assign acted =
        (action == timer_cc_pkg::OUT_SET) ? 1'b1 :
        (action == timer_cc_pkg::OUT_CLEAR) ? 1'b0 :
        (action == timer_cc_pkg::OUT_TOGGLE) ? ~oc_state_reg[n] :
                                               oc_state_reg[n];
      // channel seven wins on masked bits
      assign oc_state_next[n] = (ch7_fire & mask7_reg[n]) ? data7_reg[n] :
                                act[n] ? acted : oc_state_reg[n];
      // both bits clear frees the pin from compare logic, unless mask7_reg claims it while channel seven is a compare
      assign owned[n] = (dir_reg[n] &
                         (action != timer_cc_pkg::OUT_DISCONNECT)) |
                        (mask7_reg[n] & dir_reg[7]);
      assign pin_out_next[n] = owned[n] ? oc_state_reg[n] :
                                          port_reg.port_value[n];
      assign pin_oe_next[n] = owned[n] | port_reg.port_dir[n];
      assign value_we[n] = wr_value_hit & (reg_index[2:0] == 3'(n));
    end
  endgenerate

  channel_value_bank #(
    .WIDTH(COUNT_WIDTH),
    .DEPTH(CHANNELS)
  ) u_values (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_cap_we(cap_evt),
    .i_cap_data(counter_reg),
    .i_bus_we(value_we),
    .i_bus_data(i_writedata[COUNT_WIDTH-1:0]),
    .o_values(values)
  );

  // ****************************************
  // flags and interrupt
  // ****************************************
  logic [7:0] flag_reg;
  logic [7:0] flag_next;
  logic [7:0] clear_mask;
  logic irq_reg;
  logic [7:0] pin_out_reg;
  logic [7:0] pin_oe_reg;

  // clear only honoured while the timer runs
  assign clear_mask = (wr_clear & sys_reg.timer_enable) ? i_writedata[7:0] :
                                                      timer_cc_pkg::BYTE_RESET;
  // new events win over a clear in the same cycle
  assign flag_next = (flag_reg & ~clear_mask) | cap_evt | oc_fire;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flag_reg <= timer_cc_pkg::BYTE_RESET;
      irq_reg <= 1'b0;
      pin_prev_reg <= timer_cc_pkg::BYTE_RESET;
      oc_state_reg <= timer_cc_pkg::BYTE_RESET;
      pin_out_reg <= timer_cc_pkg::BYTE_RESET;
      pin_oe_reg <= timer_cc_pkg::BYTE_RESET;
    end else begin
      flag_reg <= flag_next;
      irq_reg <= |(flag_reg & irq_en_reg);
      pin_prev_reg <= i_capture_pin;
      oc_state_reg <= oc_state_next;
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  logic rd_value_hit;
  assign rd_value_hit =
    (reg_index[5:3] == timer_cc_pkg::IDX_CH_VALUE_BASE[5:3]);
  assign rd_word =
    (reg_index == timer_cc_pkg::IDX_DIRECTION) ? {24'h000000, dir_reg} :
    (reg_index == timer_cc_pkg::IDX_OC7_MASK) ? {24'h000000, mask7_reg} :
    (reg_index == timer_cc_pkg::IDX_OC7_DATA) ? {24'h000000, data7_reg} :
    (reg_index == timer_cc_pkg::IDX_COUNTER) ? 32'(counter_reg) :
    (reg_index == timer_cc_pkg::IDX_SYS_CTRL) ? {27'h0000000, sys_reg} :
    (reg_index == timer_cc_pkg::IDX_OUT_CTRL) ? {16'h0000, out_ctrl_reg} :
    (reg_index == timer_cc_pkg::IDX_EDGE_HIGH) ?
      {24'h000000, edge_ctrl_reg[15:8]} :
    (reg_index == timer_cc_pkg::IDX_EDGE_CTRL) ?
      {24'h000000, edge_ctrl_reg[7:0]} :
    (reg_index == timer_cc_pkg::IDX_IRQ_ENABLE) ? {24'h000000, irq_en_reg} :
    (reg_index == timer_cc_pkg::IDX_PORT_LATCH) ? {16'h0000, port_reg} :
    (reg_index == timer_cc_pkg::IDX_STATUS) ? {24'h000000, flag_reg} :
    rd_value_hit ? 32'(values[reg_index[2:0]]) :
    timer_cc_pkg::WORD_ZERO;

  assign o_readdata = readdata_reg;
  assign o_waitrequest = waitrequest_reg;
  assign o_irq = irq_reg;
  assign o_pin_out = pin_out_reg;
  assign o_pin_oe = pin_oe_reg;

endmodule : timer_capture_compare_channels

// ### verilog/timer_cc_pkg.sv
// constants and types shared by the capture/compare timer block
package timer_cc_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int CHANNELS = 8;
  localparam int COUNT_WIDTH = 16;
  localparam int PRESCALE_WIDTH = 7;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [5:0] IDX_DIRECTION = 6'h00;
  localparam logic [5:0] IDX_FORCE = 6'h01;
  localparam logic [5:0] IDX_OC7_MASK = 6'h02;
  localparam logic [5:0] IDX_OC7_DATA = 6'h03;
  localparam logic [5:0] IDX_COUNTER = 6'h04;
  localparam logic [5:0] IDX_SYS_CTRL = 6'h06;
  localparam logic [5:0] IDX_OUT_CTRL = 6'h08;
  localparam logic [5:0] IDX_EDGE_HIGH = 6'h09;
  localparam logic [5:0] IDX_EDGE_CTRL = 6'h0A;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h0C;
  localparam logic [5:0] IDX_PORT_LATCH = 6'h0D;
  localparam logic [5:0] IDX_STATUS = 6'h0E;
  localparam logic [5:0] IDX_CLEAR = 6'h0F;
  localparam logic [5:0] IDX_CH_VALUE_BASE = 6'h10;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] HALF_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;
  localparam logic [6:0] PRESCALE_RESET = 7'h00;

  // ****************************************
  // field layouts
  // ****************************************
  typedef struct packed {
    logic [2:0] prescale;
    logic counter_reset_enable;
    logic timer_enable;
  } sys_ctrl_type;

  localparam sys_ctrl_type SYS_CTRL_RESET = 5'h00;

  typedef struct packed {
    logic [7:0] port_dir;
    logic [7:0] port_value;
  } port_latch_type;

  localparam port_latch_type PORT_LATCH_RESET = 16'h0000;

  // ****************************************
  // encodings
  // ****************************************
  // {output_mode_bit, output_level_bit}
  typedef enum logic [1:0] {
    OUT_DISCONNECT = 2'b00,
    OUT_TOGGLE = 2'b01,
    OUT_CLEAR = 2'b10,
    OUT_SET = 2'b11
  } out_action_type;

  // {edge_select_high, edge_select_low}
  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_ANY = 2'b11
  } capture_edge_type;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_type;

endpackage : timer_cc_pkg

// ### verilog/channel_value_bank.sv
// bank of per-channel value registers, capture writes win over bus writes
`timescale 1ns/1ps
module channel_value_bank #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [DEPTH-1:0] i_cap_we,
  input wire logic [WIDTH-1:0] i_cap_data,
  input wire logic [DEPTH-1:0] i_bus_we,
  input wire logic [WIDTH-1:0] i_bus_data,
  output logic [DEPTH-1:0][WIDTH-1:0] o_values
);

  // ****************************************
  // one register per entry
  // ****************************************
  genvar n;
  generate
    for (n = 0; n < DEPTH; n++) begin : g_entry
      logic [WIDTH-1:0] value_reg;
      logic [WIDTH-1:0] value_next;
      assign value_next = i_cap_we[n] ? i_cap_data :
                          i_bus_we[n] ? i_bus_data : value_reg;
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          value_reg <= '0;
        end else begin
          value_reg <= value_next;
        end
      end
      assign o_values[n] = value_reg;
    end
  endgenerate

endmodule : channel_value_bank

// ### testbench/timer_cc_checker.sv
// port assertions for the capture/compare timer
`timescale 1ns/1ps
module timer_cc_checker #(
  parameter int CHANNELS = 8,
  parameter int COUNT_WIDTH = 16
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic o_irq,
  input wire logic [7:0] i_capture_pin,
  input wire logic [7:0] o_pin_out,
  input wire logic [7:0] o_pin_oe
);
  // ****************************************
  // helpers
  // ****************************************
  wire [5:0] idx = i_address[7:2];
  wire rd_done = i_read && !o_waitrequest;
  wire wr_done = i_write && !o_waitrequest;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  // ****************************************
  // assertions
  // ****************************************
  chk_wait_single: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_wait_cause: assert property (!o_waitrequest |-> (i_read || i_write))
    else $error("answer without a request");
  chk_answer_bound: assert property ((i_read || i_write) && o_waitrequest
    |-> ##[1:2] !o_waitrequest)
    else $error("request not answered in time");
  chk_rdata_hold: assert property (o_waitrequest |-> $stable(o_readdata))
    else $error("read data changed outside an answer");
  chk_wo_zero: assert property (rd_done && (idx == 6'h01 || idx == 6'h0F
    || idx == 6'h05) |-> o_readdata == 32'h00000000)
    else $error("write-only or unmapped read not zero");
  chk_byte_upper: assert property (rd_done && idx <= 6'h03
    |-> o_readdata[31:8] == 24'h000000)
    else $error("byte register upper bits set");
  chk_count_upper: assert property (rd_done && idx == 6'h04
    |-> (o_readdata >> COUNT_WIDTH) == 32'h00000000)
    else $error("counter read too wide");
  chk_value_upper: assert property (rd_done && idx[5:3] == 3'h2
    |-> (o_readdata >> COUNT_WIDTH) == 32'h00000000)
    else $error("channel value read too wide");
  chk_irq_masked: assert property (wr_done && idx == 6'h0C
    && i_writedata[7:0] == 8'h00 |-> ##[1:2] !o_irq)
    else $error("interrupt stays high with all enables off");
endmodule : timer_cc_checker

bind timer_capture_compare_channels timer_cc_checker #(
  .CHANNELS(CHANNELS), .COUNT_WIDTH(COUNT_WIDTH)) i_checker (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_address(i_address),
  .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
  .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_irq(o_irq),
  .i_capture_pin(i_capture_pin), .o_pin_out(o_pin_out),
  .o_pin_oe(o_pin_oe));

// ### testbench/capture_pin_source.sv
// far-side pin model: holds each new capture level for four clocks
`timescale 1ns/1ps
module capture_pin_source (
  input wire logic i_clk,
  input wire logic [7:0] i_level,
  output logic [7:0] o_pin,
  output logic o_busy
);
  logic [1:0] hold_reg;
  initial begin
    o_pin = 8'h00;
    hold_reg = 2'h0;
  end
  always @(posedge i_clk) begin
    if (hold_reg != 2'h0) begin
      hold_reg <= hold_reg - 2'h1;
    end else if (i_level != o_pin) begin
      o_pin <= i_level;
      hold_reg <= 2'h3;
    end
  end
  assign o_busy = (hold_reg != 2'h0) || (i_level != o_pin);
endmodule : capture_pin_source

// ### testbench/timer_capture_compare_channels_bench.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/1ps
module timer_capture_compare_channels_bench;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] i_address = 8'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h00000000;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic o_irq;
  logic [7:0] o_pin_out;
  logic [7:0] o_pin_oe;
  logic [7:0] pin_level = 8'h00;
  logic [7:0] capture_pin;
  logic pins_busy;
  logic [31:0] exp_q[$];
  logic [16:0] pin_q[$];
  logic [16:0] pin_exp;
  logic [31:0] rnd;
  logic [5:0] reset_idx [6] = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h0A, 6'h0E};
  int errors = 0;
  int compares = 0;
  int cycles = 0;

  always #12.5 i_clk = ~i_clk;

  timer_capture_compare_channels i_dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_irq(o_irq), .i_capture_pin(capture_pin),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));
  capture_pin_source i_pins (.i_clk(i_clk), .i_level(pin_level),
    .o_pin(capture_pin), .o_busy(pins_busy));

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    if (errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic bus_wr(input logic [5:0] idx, input logic [31:0] d);
    i_write <= 1'b1;
    i_address <= {idx, 2'b00};
    i_writedata <= d;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    i_write <= 1'b0;
    @(posedge i_clk);
  endtask : bus_wr

  task automatic bus_rd(input logic [5:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    i_read <= 1'b1;
    i_address <= {idx, 2'b00};
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    i_read <= 1'b0;
    @(posedge i_clk);
  endtask : bus_rd

  task automatic settle();
    do @(posedge i_clk); while (pins_busy);
    repeat (2) @(posedge i_clk);
  endtask : settle

  task automatic pin_chk(input logic [7:0] po, input logic [7:0] oe,
                         input logic irq);
    pin_q.push_back({irq, oe, po});
    @(posedge i_clk);
  endtask : pin_chk

  // ****************************************
  // read monitor and timeout
  // ****************************************
  always @(posedge i_clk) begin
    if (i_read && o_waitrequest === 1'b0 && exp_q.size() > 0) begin
      check(o_readdata, exp_q.pop_front());
    end
  end

  // pin expectations are looked at mid-cycle, when the outputs are settled
  always @(negedge i_clk) begin
    if (pin_q.size() > 0) begin
      pin_exp = pin_q.pop_front();
      check({24'h000000, o_pin_out}, {24'h000000, pin_exp[7:0]});
      check({24'h000000, o_pin_oe}, {24'h000000, pin_exp[15:8]});
      check({31'h00000000, o_irq}, {31'h00000000, pin_exp[16]});
    end
  end

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      finish_test();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(9));
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    foreach (reset_idx[i]) bus_rd(reset_idx[i], 32'h00000000);
    rnd = $urandom;
    bus_wr(6'h0A, rnd);
    bus_rd(6'h0A, rnd & 32'h000000FF);
    bus_wr(6'h05, rnd);
    bus_rd(6'h05, 32'h00000000);
    bus_rd(6'h01, 32'h00000000);
    bus_wr(6'h06, 32'h00000001);
    bus_wr(6'h06, 32'h00000000);
    bus_rd(6'h04, 32'h00000003);
    bus_wr(6'h0A, 32'h000000E4);
    bus_wr(6'h0C, 32'h00000002);
    pin_level <= 8'h0F;
    settle();
    bus_rd(6'h0E, 32'h0000000A);
    pin_chk(8'h00, 8'h00, 1'b1);
    pin_level <= 8'h00;
    settle();
    bus_rd(6'h0E, 32'h0000000E);
    bus_rd(6'h11, 32'h00000003);
    bus_rd(6'h10, 32'h00000000);
    bus_wr(6'h0C, 32'h00000000);
    pin_chk(8'h00, 8'h00, 1'b0);
    bus_wr(6'h0F, 32'h000000FF);
    bus_rd(6'h0E, 32'h0000000E);
    bus_wr(6'h06, 32'h00000001);
    bus_wr(6'h0F, 32'h000000FF);
    bus_wr(6'h06, 32'h00000000);
    bus_rd(6'h0E, 32'h00000000);
    bus_rd(6'h04, 32'h00000009);
    bus_wr(6'h00, 32'h000000F0);
    bus_wr(6'h08, 32'h00001F00);
    bus_wr(6'h01, 32'h00000020);
    pin_chk(8'h20, 8'h70, 1'b0);
    bus_rd(6'h0E, 32'h00000000);
    bus_wr(6'h08, 32'h00001B00);
    bus_wr(6'h14, 32'h00000014);
    bus_wr(6'h15, 32'h0000000C);
    bus_wr(6'h16, 32'h0000000C);
    bus_wr(6'h17, 32'h00000014);
    bus_wr(6'h02, 32'h00000010);
    bus_wr(6'h06, 32'h00000003);
    repeat (5) @(posedge i_clk);
    pin_chk(8'h40, 8'h70, 1'b0);
    bus_rd(6'h0E, 32'h00000060);
    repeat (6) @(posedge i_clk);
    pin_chk(8'h40, 8'h70, 1'b0);
    repeat (19) @(posedge i_clk);
    bus_wr(6'h06, 32'h00000000);
    bus_rd(6'h04, 32'h00000005);
    // divide by two over four enabled cycles gives two ticks in any phase
    bus_wr(6'h06, 32'h00000005);
    @(posedge i_clk);
    bus_wr(6'h06, 32'h00000000);
    bus_rd(6'h04, 32'h00000007);
    bus_wr(6'h0D, 32'h0000F0A0);
    pin_chk(8'h80, 8'hF0, 1'b0);
    bus_wr(6'h00, 32'h00000000);
    @(posedge i_clk);
    pin_chk(8'hA0, 8'hF0, 1'b0);
    finish_test();
  end
endmodule : timer_capture_compare_channels_bench
